// file: verif/pmcd_wake_src.sv
// far-side model: reset pin, rtc wake source and free-running input clock
`timescale 1ns/1ns
module pmcd_wake_src (
  input  wire logic pclk,
  input  wire logic rst_req,
  input  wire logic wake_req,
  input  wire logic slow,
  output logic      presetn,
  output logic      rtc_wake,
  output logic      input_clk_pin
);
  logic [1:0] ph_q  = 2'h0;
  logic [3:0] dly_q = 4'h0;
  logic       req_q = 1'b0;
  initial presetn = 1'b0;
  initial rtc_wake = 1'b0;
  initial input_clk_pin = 1'b0;
  // reset pin follows the request, moved only just after an edge
  always @(posedge pclk) presetn <= ~rst_req;
  // input clock: one level per three pclk cycles, so a period of six
  always @(posedge pclk) begin
    ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    if (ph_q == 2'h2) input_clk_pin <= ~input_clk_pin;
  end
  // one wake pulse per request, prompt or late, never a held level
  always @(posedge pclk) begin
    req_q <= wake_req;
    rtc_wake <= 1'b0;
    if (wake_req && !req_q) dly_q <= slow ? 4'h9 : 4'h1;
    else if (dly_q != 4'h0) begin
      dly_q <= dly_q - 4'h1;
      rtc_wake <= (dly_q == 4'h1);
    end
  end
endmodule // pmcd_wake_src

// file: verif/test_power_mode_clock_divider.sv
// self-checking bench of the power mode and clock divider block
`timescale 1ns/1ns
module test_power_mode_clock_divider;
  import pmcd_pkg::*;
  logic          pclk = 1'b0;
  logic          presetn, rtc_wake, input_clk_pin;
  logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0;
  logic          pready, pslverr, core_clk_tick, sys_clk_tick;
  logic [31:0]   prdata, rd, per;
  pmcd_clk_cfg_t clk_cfg;
  logic          pll_enable, pll_bypass, rtc_access_grant, boot_start;
  logic          internal_supply_on, regulator_bypass, err;
  logic [11:0]   core_voltage_mv;
  logic [7:0]    pin_oe_n;
  logic          rst_req = 1'b1, wake_req = 1'b0, slow = 1'b0;
  logic          boot_prev = 1'b0;
  int            miscompares = 0, num_checks = 0, boots = 0, cycles = 0;

  pmcd_power_clock #(.PIN_COUNT(8)) u_dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .input_clk_pin, .rtc_wake, .core_clk_tick, .sys_clk_tick, .clk_cfg,
    .pll_enable, .pll_bypass, .rtc_access_grant, .internal_supply_on,
    .regulator_bypass, .core_voltage_mv, .boot_start, .pin_oe_n);
  pmcd_wake_src u_src (.pclk, .rst_req, .wake_req, .slow, .presetn,
    .rtc_wake, .input_clk_pin);

  always #10 pclk = ~pclk;

  // boot pulses counted by rising edge, since reset holds the line high
  always @(posedge pclk) begin
    boot_prev <= boot_start;
    if (boot_start === 1'b1 && boot_prev !== 1'b1) boots++;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    idle(1);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  // second of two tick intervals, so a divisor change has settled
  task automatic period(input logic sys);
    int i, f, k;
    f = -1;
    k = 0;
    per = 32'hFFFFFFFF;
    for (i = 0; i < 300 && k < 3; i++) begin
      @(negedge pclk);
      if ((sys ? sys_clk_tick : core_clk_tick) === 1'b1) begin
        if (f >= 0) per = i - f;
        f = i;
        k++;
      end
    end
  endtask

  task automatic quiet();
    int i, n;
    n = 0;
    for (i = 0; i < 24; i++) begin
      @(negedge pclk);
      if (sys_clk_tick !== 1'b0 || core_clk_tick !== 1'b0) n++;
    end
    chk(n, 0);
  endtask

  task automatic fire(input logic s);
    @(posedge pclk);
    wake_req <= 1'b1;
    slow <= s;
    repeat (14) @(posedge pclk);
    wake_req <= 1'b0;
    idle(1);
  endtask

  task automatic do_reset();
    @(posedge pclk);
    rst_req <= 1'b1;
    repeat (2) @(posedge pclk);
    rst_req <= 1'b0;
    idle(3);
  endtask

  task automatic t_reset();
    chk(boots, 1);
    rdchk(PMCD_OFF_STATUS, 32'hFFFFFFFF, 32'h08);
    rdchk(PMCD_OFF_PLL_CTL, 32'hFFFFFFFF, 32'h14);
    rdchk(PMCD_OFF_CLK_DIV, 32'hFFFFFFFF, 32'h05);
    rdchk(PMCD_OFF_REG_CTL, 32'hFFFFFFFF, 32'h83);
    chk(core_voltage_mv, 12'h44C);
    chk(pin_oe_n, 8'h00);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 8'h10, 32'hFFFF);
    chk(err, 1'b1);
    chk(clk_cfg.ssel, PMCD_SSEL_RESET);
  endtask

  // divisors kept in range so the system clock stays legal
  task automatic t_div();
    logic [3:0] s [4] = '{4'h1, 4'h5, 4'hA, 4'hF};
    int i;
    for (i = 0; i < 4; i++) begin
      apb(1'b1, PMCD_OFF_CLK_DIV, {26'h0, i[1:0], s[i]});
      chk(clk_cfg.ssel, s[i]);
      chk(clk_cfg.csel, i[1:0]);
      period(1'b1);
      chk(per, s[i]);
      period(1'b0);
      chk(per, 32'h1 << i);
    end
    apb(1'b1, PMCD_OFF_CLK_DIV, 32'h20);
    rdchk(PMCD_OFF_CLK_DIV, 32'hFF, 32'h2F);
    period(1'b1);
    chk(per, 32'hF);
    apb(1'b1, PMCD_OFF_CLK_DIV, 32'h05);
  endtask

  task automatic t_mult();
    logic [7:0] w [4] = '{8'h80, 8'h00, 8'h01, 8'h81};
    logic [7:0] e [4] = '{8'h80, 8'h80, 8'h01, 8'h01};
    int i;
    for (i = 0; i < 4; i++) begin
      apb(1'b1, PMCD_OFF_PLL_CTL, {24'h0, w[i]});
      rdchk(PMCD_OFF_PLL_CTL, 32'hFF, e[i]);
      chk(clk_cfg.mult, e[i]);
    end
    apb(1'b1, PMCD_OFF_PLL_CTL, 32'h14);
  endtask

  task automatic t_reg();
    apb(1'b1, PMCD_OFF_REG_CTL, 32'h33);
    idle(2);
    chk(core_voltage_mv, 12'h352);
    apb(1'b1, PMCD_OFF_REG_CTL, 32'h180);
    idle(2);
    chk({regulator_bypass, internal_supply_on}, 2'b10);
    rdchk(PMCD_OFF_STATUS, 32'h3, 32'h0);
    apb(1'b1, PMCD_OFF_REG_CTL, 32'h83);
    idle(2);
    chk({regulator_bypass, internal_supply_on}, 2'b01);
    chk(core_voltage_mv, 12'h44C);
  endtask

  task automatic t_deep();
    int b;
    fire(1'b0);
    rdchk(PMCD_OFF_STATUS, 32'h7, 32'h0);
    apb(1'b1, PMCD_OFF_PLL_CTL, 32'h1014);
    chk(rtc_access_grant, 1'b0);
    quiet();
    apb(1'b1, PMCD_OFF_CLK_DIV, 32'h01);
    chk(err, 1'b1);
    rdchk(PMCD_OFF_STATUS, 32'h3, 32'h1);
    fire(1'b1);
    rdchk(PMCD_OFF_STATUS, 32'h1F, 32'h1C);
    chk({pll_bypass, rtc_access_grant}, 2'b11);
    apb(1'b1, PMCD_OFF_STATUS, 32'h10);
    rdchk(PMCD_OFF_STATUS, 32'h10, 32'h0);
    rdchk(PMCD_OFF_CLK_DIV, 32'hFF, 32'h05);
    period(1'b1);
    chk(per, 32'h6);
    period(1'b0);
    chk(per, 32'h6);
    // deep again with bypass on: only a reset may bring back full-on
    apb(1'b1, PMCD_OFF_PLL_CTL, 32'h1114);
    b = boots;
    do_reset();
    chk(boots, b + 1);
    rdchk(PMCD_OFF_STATUS, 32'h1F, 32'h08);
    period(1'b1);
    chk(per, 32'h5);
  endtask

  task automatic t_hib();
    int b;
    b = boots;
    apb(1'b1, PMCD_OFF_REG_CTL, 32'h80);
    idle(2);
    chk(pin_oe_n, 8'hFF);
    chk({internal_supply_on, core_voltage_mv}, 13'h0);
    quiet();
    rdchk(PMCD_OFF_STATUS, 32'h3, 32'h2);
    fire(1'b0);
    chk(pin_oe_n, 8'h00);
    chk(boots, b + 1);
    rdchk(PMCD_OFF_REG_CTL, 32'h3, 32'h3);
    chk(pll_bypass, 1'b0);
    apb(1'b1, PMCD_OFF_REG_CTL, 32'h80);
    do_reset();
    chk(boots, b + 2);
    chk(internal_supply_on, 1'b1);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    rst_req <= 1'b0;
    idle(3);
    t_reset();
    t_div();
    t_mult();
    t_reg();
    t_deep();
    t_hib();
    final_report();
  end
endmodule // test_power_mode_clock_divider

// file: verilog/pmcd_clk_div.sv
// tick divider: one output tick per div source ticks
`timescale 1ns/1ns
module pmcd_clk_div #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         run,
  input  wire logic         src_tick,
  input  wire logic [W-1:0] div,
  output logic              tick_q
);
  logic [W-1:0] cnt_q;

  generate
    if (W < 1) begin : g_bad_w
      $error("pmcd_clk_div: W must be at least 1");
    end
  endgenerate

  // a smaller new divisor takes effect at once, no wait for a wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (!run) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (src_tick) begin
      if (cnt_q + W'(1) >= div) begin
        cnt_q  <= '0;
        tick_q <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + W'(1);
        tick_q <= 1'b0;
      end
    end else begin
      tick_q <= 1'b0;
    end
  end

endmodule // pmcd_clk_div

// file: verilog/pmcd_pkg.sv
// shared constants and types of the power mode and clock divider block
package pmcd_pkg;

  // register byte offsets
  localparam logic [7:0] PMCD_OFF_PLL_CTL = 8'h00;
  localparam logic [7:0] PMCD_OFF_CLK_DIV = 8'h04;
  localparam logic [7:0] PMCD_OFF_REG_CTL = 8'h08;
  localparam logic [7:0] PMCD_OFF_STATUS  = 8'h0C;

  // pll control fields
  localparam int PMCD_MULT_LSB   = 0;
  localparam int PMCD_MULT_W     = 8;
  localparam int PMCD_BYPASS_BIT = 8;
  localparam int PMCD_PLLOFF_BIT = 9;
  localparam int PMCD_DEEP_BIT   = 12;

  // multiplier in half steps: 1 is 0.5x, 128 is 64x
  localparam logic [7:0] PMCD_MULT_MIN   = 8'h01;
  localparam logic [7:0] PMCD_MULT_MAX   = 8'h80;
  localparam logic [7:0] PMCD_MULT_RESET = 8'h14;

  // clock divide fields
  localparam int PMCD_SSEL_LSB = 0;
  localparam int PMCD_CSEL_LSB = 4;
  localparam logic [3:0] PMCD_SSEL_RESET = 4'h5;
  localparam logic [1:0] PMCD_CSEL_RESET = 2'h0;

  // regulator control fields
  localparam int PMCD_REGULATOR_SWITCH_FIELD_A_LSB    = 0;
  localparam int PMCD_VLEVEL_LSB  = 4;
  localparam int PMCD_VRBYP_BIT   = 8;
  localparam logic [1:0] PMCD_REGULATOR_SWITCH_FIELD_A_OFF    = 2'h0;
  localparam logic [1:0] PMCD_REGULATOR_SWITCH_FIELD_A_RESET  = 2'h3;
  localparam logic [3:0] PMCD_VLEVEL_RESET = 4'h8;
  localparam logic [11:0] PMCD_VR_BASE_MV = 12'h2BC;
  localparam logic [11:0] PMCD_VR_STEP_MV = 12'h032;

  // status fields
  localparam int PMCD_ST_BYP_BIT  = 2;
  localparam int PMCD_ST_PLL_BIT  = 3;
  localparam int PMCD_ST_WOKE_BIT = 4;

  typedef enum logic [1:0] {
    PMCD_RUN  = 2'b00,
    PMCD_DEEP = 2'b01,
    PMCD_HIB  = 2'b10
  } pmcd_state_t;

  typedef struct packed {
    logic [7:0] mult;
    logic [3:0] ssel;
    logic [1:0] csel;
  } pmcd_clk_cfg_t;

endpackage

// file: verilog/pmcd_power_clock.sv
// power mode control and core/system clock derivation with apb registers
`timescale 1ns/1ns
module pmcd_power_clock
  import pmcd_pkg::*;
#(
  parameter int PIN_COUNT = 8
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  input  wire logic                     input_clk_pin,
  input  wire logic                     rtc_wake,
  output logic                          core_clk_tick,
  output logic                          sys_clk_tick,
  output pmcd_pkg::pmcd_clk_cfg_t       clk_cfg,
  output logic                          pll_enable,
  output logic                          pll_bypass,
  output logic                          rtc_access_grant,
  output logic                          internal_supply_on,
  output logic                          regulator_bypass,
  output logic [11:0]                   core_voltage_mv,
  output logic                          boot_start,
  output logic [PIN_COUNT-1:0]          pin_oe_n
);
  import pmcd_pkg::*;

  generate
    if (PIN_COUNT < 1) begin : g_bad_pins
      $error("pmcd_power_clock: PIN_COUNT must be at least 1");
    end
  endgenerate

  pmcd_state_t   state_q;
  pmcd_clk_cfg_t cfg_q;
  logic          bypass_q;
  logic          pll_off_q;
  logic [1:0]    regulator_switch_field_a_q;
  logic [3:0]    vlevel_q;
  logic          vr_byp_q;
  logic          woke_q;
  logic          boot_q;
  logic          first_q;
  logic          in_q;
  logic [31:0]   prdata_q;
  logic [11:0]   mv_q;

  logic          wr;
  logic          rd_setup;
  logic          mapped;
  logic          refuse;
  logic          wr_ctl;
  logic          wr_div;
  logic          wr_reg;
  logic          wr_sts;
  logic [7:0]    new_mult;
  logic [3:0]    new_ssel;
  logic [1:0]    new_csel;
  logic [1:0]    new_regulator_switch_field_a;
  logic          run;
  logic          div_run;
  logic          src_tick;
  logic [3:0]    core_div;
  logic [3:0]    sys_div;
  logic          hib_enter;
  logic          deep_enter;

  function automatic logic [3:0] csel_div(input logic [1:0] sel);
    csel_div = 4'h1 << sel;
  endfunction

  // ---------------- apb slave, zero wait states ----------------
  assign pready   = 1'b1;
  assign mapped   = (paddr == PMCD_OFF_PLL_CTL) ||
                    (paddr == PMCD_OFF_CLK_DIV) ||
                    (paddr == PMCD_OFF_REG_CTL) ||
                    (paddr == PMCD_OFF_STATUS);
  // software cannot wake the part: writes are refused while asleep
  assign refuse   = pwrite && (state_q != PMCD_RUN);
  assign pslverr  = psel && penable && (!mapped || refuse);
  assign wr       = psel && penable && pwrite && mapped && !refuse;
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_ctl   = wr && (paddr == PMCD_OFF_PLL_CTL);
  assign wr_div   = wr && (paddr == PMCD_OFF_CLK_DIV);
  assign wr_reg   = wr && (paddr == PMCD_OFF_REG_CTL);
  assign wr_sts   = wr && (paddr == PMCD_OFF_STATUS);
  assign prdata   = prdata_q;

  assign new_mult = pwdata[PMCD_MULT_LSB +: PMCD_MULT_W];
  assign new_ssel = pwdata[PMCD_SSEL_LSB +: 4];
  assign new_csel = pwdata[PMCD_CSEL_LSB +: 2];
  assign new_regulator_switch_field_a = pwdata[PMCD_REGULATOR_SWITCH_FIELD_A_LSB +: 2];

  // read data is captured in the setup phase so it leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_q <= 32'h0000_0000;
      unique case (paddr)
        PMCD_OFF_PLL_CTL: begin
          prdata_q[PMCD_MULT_LSB +: PMCD_MULT_W] <= cfg_q.mult;
          prdata_q[PMCD_BYPASS_BIT]              <= bypass_q;
          prdata_q[PMCD_PLLOFF_BIT]              <= pll_off_q;
        end
        PMCD_OFF_CLK_DIV: begin
          prdata_q[PMCD_SSEL_LSB +: 4] <= cfg_q.ssel;
          prdata_q[PMCD_CSEL_LSB +: 2] <= cfg_q.csel;
        end
        PMCD_OFF_REG_CTL: begin
          prdata_q[PMCD_REGULATOR_SWITCH_FIELD_A_LSB +: 2]   <= regulator_switch_field_a_q;
          prdata_q[PMCD_VLEVEL_LSB +: 4] <= vlevel_q;
          prdata_q[PMCD_VRBYP_BIT]       <= vr_byp_q;
        end
        PMCD_OFF_STATUS: begin
          prdata_q[1:0]              <= state_q;
          prdata_q[PMCD_ST_BYP_BIT]  <= bypass_q;
          prdata_q[PMCD_ST_PLL_BIT]  <= pll_enable;
          prdata_q[PMCD_ST_WOKE_BIT] <= woke_q;
        end
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------- power state ----------------
  // a bypassed regulator is already off, so a zero field then does nothing
  assign hib_enter  = wr_reg && (new_regulator_switch_field_a == PMCD_REGULATOR_SWITCH_FIELD_A_OFF) &&
                      !pwdata[PMCD_VRBYP_BIT] && !vr_byp_q;
  assign deep_enter = wr_ctl && pwdata[PMCD_DEEP_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= PMCD_RUN;
    end else begin
      unique case (state_q)
        PMCD_RUN: begin
          if (hib_enter) begin
            state_q <= PMCD_HIB;
          end else if (deep_enter) begin
            state_q <= PMCD_DEEP;
          end
        end
        PMCD_DEEP: begin
          if (rtc_wake) begin
            state_q <= PMCD_RUN;
          end
        end
        PMCD_HIB: begin
          if (rtc_wake) begin
            state_q <= PMCD_RUN;
          end
        end
        default: state_q <= PMCD_RUN;
      endcase
    end
  end

  // full-on after reset; rtc wake from deep sleep forces bypass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bypass_q  <= 1'b0;
      pll_off_q <= 1'b0;
    end else if (state_q == PMCD_DEEP && rtc_wake) begin
      bypass_q  <= 1'b1;
      pll_off_q <= 1'b0;
    end else if (state_q == PMCD_HIB && rtc_wake) begin
      bypass_q  <= 1'b0;
      pll_off_q <= 1'b0;
    end else if (wr_ctl) begin
      // pll may only be off while bypassed; leaving bypass needs it on
      if (pwdata[PMCD_BYPASS_BIT]) begin
        bypass_q  <= 1'b1;
        pll_off_q <= pwdata[PMCD_PLLOFF_BIT];
      end else if (!pwdata[PMCD_PLLOFF_BIT]) begin
        bypass_q  <= 1'b0;
        pll_off_q <= 1'b0;
      end
    end
  end

  // reserved codes leave the previous value in force
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q.mult <= PMCD_MULT_RESET;
      cfg_q.ssel <= PMCD_SSEL_RESET;
      cfg_q.csel <= PMCD_CSEL_RESET;
    end else begin
      if (wr_ctl && new_mult >= PMCD_MULT_MIN &&
          new_mult <= PMCD_MULT_MAX) begin
        cfg_q.mult <= new_mult;
      end
      if (wr_div && new_ssel != 4'h0) begin
        cfg_q.ssel <= new_ssel;
      end
      if (wr_div) begin
        cfg_q.csel <= new_csel;
      end
    end
  end

  // regulator: a hibernate wake restores the field so the supply comes back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_switch_field_a_q   <= PMCD_REGULATOR_SWITCH_FIELD_A_RESET;
      vlevel_q <= PMCD_VLEVEL_RESET;
      vr_byp_q <= 1'b0;
    end else if (state_q == PMCD_HIB && rtc_wake) begin
      regulator_switch_field_a_q <= PMCD_REGULATOR_SWITCH_FIELD_A_RESET;
    end else if (wr_reg) begin
      regulator_switch_field_a_q   <= new_regulator_switch_field_a;
      vlevel_q <= pwdata[PMCD_VLEVEL_LSB +: 4];
      vr_byp_q <= pwdata[PMCD_VRBYP_BIT];
    end
  end

  // sticky rtc wake cause; a new wake beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      woke_q <= 1'b0;
    end else if (state_q != PMCD_RUN && rtc_wake) begin
      woke_q <= 1'b1;
    end else if (wr_sts && pwdata[PMCD_ST_WOKE_BIT]) begin
      woke_q <= 1'b0;
    end
  end

  // boot pulse after reset release and after a hibernate wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q  <= 1'b1;
      first_q <= 1'b1;
    end else begin
      boot_q  <= (state_q == PMCD_HIB) && rtc_wake;
      first_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mv_q <= 12'h000;
    end else if (state_q == PMCD_HIB || vr_byp_q) begin
      mv_q <= 12'h000;
    end else begin
      mv_q <= PMCD_VR_BASE_MV + 12'(vlevel_q) * PMCD_VR_STEP_MV;
    end
  end

  // ---------------- clock derivation ----------------
  // pclk stands for the vco; input clock edges drive the bypass path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_q <= 1'b0;
    end else begin
      in_q <= input_clk_pin;
    end
  end

  assign run      = (state_q == PMCD_RUN);
  // stop ticks at the entry edge so no late tick lands in a sleep state
  assign div_run  = run && !hib_enter && !deep_enter;
  assign src_tick = bypass_q ? (input_clk_pin && !in_q) : 1'b1;
  // bypass feeds the input clock straight through to both clocks
  assign core_div = bypass_q ? 4'h1 : csel_div(cfg_q.csel);
  assign sys_div  = bypass_q ? 4'h1 : cfg_q.ssel;

  pmcd_clk_div #(.W(4)) u_core_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (div_run),
    .src_tick (src_tick),
    .div      (core_div),
    .tick_q   (core_clk_tick)
  );

  // every peripheral runs from this one tick
  pmcd_clk_div #(.W(4)) u_sys_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (div_run),
    .src_tick (src_tick),
    .div      (sys_div),
    .tick_q   (sys_clk_tick)
  );

  assign clk_cfg            = cfg_q;
  assign pll_enable         = run && !pll_off_q;
  assign pll_bypass         = bypass_q;
  assign rtc_access_grant   = run;
  assign internal_supply_on = (state_q != PMCD_HIB) && !vr_byp_q;
  assign regulator_bypass   = vr_byp_q;
  assign core_voltage_mv    = mv_q;
  assign boot_start         = boot_q;
  assign pin_oe_n = (state_q == PMCD_HIB) ? '1 : '0;

  // ---------------- assertions ----------------
  property p_deep_no_ticks;
    @(posedge pclk) disable iff (!presetn)
      (state_q == PMCD_DEEP) ##1 (state_q == PMCD_DEEP)
      |-> !core_clk_tick && !sys_clk_tick;
  endproperty
  a_deep_no_ticks: assert property (p_deep_no_ticks)
    else $error("clock tick during deep sleep");

  property p_deep_no_access;
    @(posedge pclk) disable iff (!presetn)
      (state_q != PMCD_RUN) |-> !rtc_access_grant && !pll_enable;
  endproperty
  a_deep_no_access: assert property (p_deep_no_access)
    else $error("rtc access granted while asleep");

  property p_deep_holds;
    @(posedge pclk) disable iff (!presetn)
      (state_q == PMCD_DEEP) && !rtc_wake |=> (state_q == PMCD_DEEP);
  endproperty
  a_deep_holds: assert property (p_deep_holds)
    else $error("deep sleep left without rtc wake");

  property p_rtc_to_active;
    @(posedge pclk) disable iff (!presetn)
      (state_q == PMCD_DEEP) && rtc_wake
      |=> (state_q == PMCD_RUN) && pll_bypass && !boot_start;
  endproperty
  a_rtc_to_active: assert property (p_rtc_to_active)
    else $error("rtc wake did not enter active mode");

  property p_reset_full_on;
    @(posedge pclk) disable iff (!presetn)
      first_q |-> (state_q == PMCD_RUN) && !pll_bypass && pll_enable
                  && boot_start && (clk_cfg.mult == PMCD_MULT_RESET);
  endproperty
  a_reset_full_on: assert property (p_reset_full_on)
    else $error("reset did not give full-on");

  property p_hib_entry;
    @(posedge pclk) disable iff (!presetn)
      hib_enter && (state_q == PMCD_RUN)
      |=> (state_q == PMCD_HIB) && !internal_supply_on ##1 (mv_q == 12'h000);
  endproperty
  a_hib_entry: assert property (p_hib_entry)
    else $error("regulator zero did not enter hibernate");

  property p_hib_pins;
    @(posedge pclk) disable iff (!presetn)
      (state_q == PMCD_HIB) |-> (&pin_oe_n) && !core_clk_tick;
  endproperty
  a_hib_pins: assert property (p_hib_pins)
    else $error("pins driven in hibernate");

  property p_hib_wake_boot;
    @(posedge pclk) disable iff (!presetn)
      (state_q == PMCD_HIB) && rtc_wake
      |=> (state_q == PMCD_RUN) && boot_start ##1 !boot_start;
  endproperty
  a_hib_wake_boot: assert property (p_hib_wake_boot)
    else $error("hibernate wake did not boot");

  property p_ssel_zero_kept;
    @(posedge pclk) disable iff (!presetn)
      wr_div && (new_ssel == 4'h0) |=> $stable(clk_cfg.ssel);
  endproperty
  a_ssel_zero_kept: assert property (p_ssel_zero_kept)
    else $error("reserved system select taken");

  property p_mult_range;
    @(posedge pclk) disable iff (!presetn)
      (clk_cfg.mult >= PMCD_MULT_MIN) && (clk_cfg.mult <= PMCD_MULT_MAX);
  endproperty
  a_mult_range: assert property (p_mult_range)
    else $error("pll factor out of range");

  property p_bypass_rate;
    @(posedge pclk) disable iff (!presetn)
      run && pll_bypass && $past(pll_bypass) && $past(run)
      && !(input_clk_pin && !in_q) |=> !sys_clk_tick && !core_clk_tick;
  endproperty
  a_bypass_rate: assert property (p_bypass_rate)
    else $error("bypass clock ticks without input edge");

endmodule // pmcd_power_clock
